/* File: hw/fucd_host.sv */
// Host that issues flash command sequences and sector loads over the strobes
`timescale 1ns/1ns
module fucd_host
    import fucd_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              start,
    input  wire logic [2:0]        op,
    input  wire logic              prefix,
    input  wire logic [9:0]        sector,
    input  wire logic [7:0]        wr_data,
    output logic                   data_req,
    output logic [6:0]             data_idx,
    output logic                   busy,
    output logic                   done,
    output logic [ADDR_W-1:0]      flash_addr,
    output logic [7:0]             flash_dq_out,
    output logic                   flash_dq_oe,
    output logic                   flash_ce_n,
    output logic                   flash_we_n,
    output logic                   flash_oe_n
);
    typedef enum logic [1:0] {S_IDLE, S_SETUP, S_PULSE, S_HOLD} fucd_state_e;

    fucd_state_e      state;
    fucd_op_e         cur_op;
    logic             cur_prefix;
    logic [9:0]       cur_sector;
    logic [7:0]       step;
    logic [7:0]       cnt;

    // Command step table: index into the prefix, returns {addr,data}
    function automatic logic [22:0] cmd_word(input logic [2:0] i, input fucd_op_e o);
        logic [7:0] last;
        last = CMD_PROT_OFF;
        unique case (o)
            FUCD_OP_CHIP_CLR: last = CMD_CHIP_CLR;
            FUCD_OP_ACLR_OFF: last = CMD_ACLR_OFF;
            FUCD_OP_ACLR_ON:  last = CMD_ACLR_ON;
            default:          last = CMD_PROT_OFF;
        endcase
        unique case (i)
            3'h0:    cmd_word = {CMD_ADDR_A, CMD_D1};
            3'h1:    cmd_word = {CMD_ADDR_B, CMD_D2};
            3'h2:    cmd_word = (o == FUCD_OP_PROT_ON) ? {CMD_ADDR_A, CMD_PROT_ON}
                                                       : {CMD_ADDR_A, CMD_EXT};
            3'h3:    cmd_word = {CMD_ADDR_A, CMD_D1};
            3'h4:    cmd_word = {CMD_ADDR_B, CMD_D2};
            default: cmd_word = {CMD_ADDR_A, last};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Sequence shape
    wire logic [7:0]  cmd_len;
    wire logic [7:0]  total_len;
    wire logic        in_cmd;
    wire logic [7:0]  byte_step;
    wire logic [22:0] cmd_now;
    wire logic        last_step;
    wire fucd_op_e    start_op;

    assign start_op  = (op > 3'(FUCD_OP_PLAIN)) ? FUCD_OP_PLAIN : fucd_op_e'(op);
    // Plain loads carry the three-write prefix when prefix is set
    assign cmd_len   = (cur_op == FUCD_OP_PROT_ON) ? 8'h03 :
                       (cur_op == FUCD_OP_PLAIN)   ? (cur_prefix ? 8'h03 : 8'h00) :
                       8'h06;
    // Chip clear is the only command without a sector load
    assign total_len = (cur_op == FUCD_OP_CHIP_CLR) ? cmd_len
                                                    : cmd_len + 8'(SECTOR_BYTES);
    assign in_cmd    = step < cmd_len;
    assign byte_step = step - cmd_len;
    assign cmd_now   = cmd_word(step[2:0],
                                cur_op == FUCD_OP_PLAIN ? FUCD_OP_PROT_ON : cur_op);
    assign last_step = (step + 8'h01) == total_len;

    wire logic [ADDR_W-1:0] next_addr;
    // Command addresses fill only the fifteen low bits; the sector sits above the 7-bit byte index
    assign next_addr = in_cmd ? {2'h0, cmd_now[22:8]}
                              : {cur_sector, byte_step[6:0]};

    ////////////////////////////////////////////////////////////////////////
    // Strobe sequencer; every write is the same WE-controlled cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state      <= S_IDLE;
            cur_op     <= FUCD_OP_PLAIN;
            cur_prefix <= 1'b0;
            cur_sector <= 10'h000;
            step       <= CNT_RST;
            cnt        <= CNT_RST;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (start) begin
                        state      <= S_SETUP;
                        cur_op     <= start_op;
                        cur_prefix <= prefix;
                        cur_sector <= sector;
                        step       <= CNT_RST;
                        cnt        <= CNT_RST;
                    end
                end
                S_SETUP: begin
                    cnt <= cnt + 8'h01;
                    if (cnt == 8'(SETUP_CYC - 1)) begin
                        state <= S_PULSE;
                        cnt   <= CNT_RST;
                    end
                end
                S_PULSE: begin
                    cnt <= cnt + 8'h01;
                    if (cnt == 8'(PULSE_CYC - 1)) begin
                        state <= S_HOLD;
                        cnt   <= CNT_RST;
                    end
                end
                S_HOLD: begin
                    // Back-to-back bytes: far inside the byte-load window
                    cnt <= cnt + 8'h01;
                    if (cnt == 8'(HOLD_CYC - 1)) begin
                        cnt   <= CNT_RST;
                        step  <= step + 8'h01;
                        state <= last_step ? S_IDLE : S_SETUP;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered pins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flash_addr   <= '0;
            flash_dq_out <= 8'h00;
            flash_dq_oe  <= 1'b0;
            flash_ce_n   <= 1'b1;
            flash_we_n   <= 1'b1;
            flash_oe_n   <= 1'b1;
            data_req     <= 1'b0;
            data_idx     <= 7'h00;
            busy         <= 1'b0;
            done         <= 1'b0;
        end else begin
            flash_addr   <= next_addr;
            flash_dq_out <= in_cmd ? cmd_now[7:0] : wr_data;
            flash_dq_oe  <= state != S_IDLE;
            flash_ce_n   <= state == S_IDLE;
            flash_we_n   <= state != S_PULSE;
            flash_oe_n   <= 1'b1;
            data_req     <= (state == S_SETUP) && !in_cmd;
            data_idx     <= byte_step[6:0];
            busy         <= (state != S_IDLE) || start;
            done         <= (state == S_HOLD) && (cnt == 8'(HOLD_CYC - 1)) && last_step;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_we_needs_oe_high: assert property (@(posedge clk) disable iff (!nrst)
        !flash_we_n |-> (flash_oe_n && !flash_ce_n && flash_dq_oe))
        else $error("write strobe without gate high");
    a_pulse_width: assert property (@(posedge clk) disable iff (!nrst)
        $fell(flash_we_n) |-> !flash_we_n [*8] ##1 !flash_we_n [*4] ##1 flash_we_n)
        else $error("write pulse width wrong");
    a_first_cmd_word: assert property (@(posedge clk) disable iff (!nrst)
        (state == S_IDLE && start && start_op != FUCD_OP_PLAIN) |->
        ##(SETUP_CYC + 1) (flash_addr[14:0] == CMD_ADDR_A && flash_dq_out == CMD_D1))
        else $error("sequence does not open with first unlock write");
    a_addr_high_zero: assert property (@(posedge clk) disable iff (!nrst)
        (!flash_we_n && in_cmd) |-> flash_addr[16:15] == 2'h0)
        else $error("command address carries high bits");
    // Data is taken on the rising write strobe, so select must still be low
    a_ce_over_we: assert property (@(posedge clk) disable iff (!nrst)
        $rose(flash_we_n) |-> (!flash_ce_n && flash_dq_oe))
        else $error("chip select released before write strobe");
    a_done_single: assert property (@(posedge clk) disable iff (!nrst)
        done |=> (!done && flash_ce_n))
        else $error("done not a single pulse");
endmodule

/* File: hw/fucd_pkg.sv */
// Constants for the flash command sequencer host
package fucd_pkg;
    localparam int          ADDR_W        = 17;
    localparam logic [14:0] CMD_ADDR_A    = 15'h5555;
    localparam logic [14:0] CMD_ADDR_B    = 15'h2aaa;
    localparam logic [7:0]  CMD_D1        = 8'haa;
    localparam logic [7:0]  CMD_D2        = 8'h55;
    localparam logic [7:0]  CMD_PROT_ON   = 8'ha0;
    localparam logic [7:0]  CMD_EXT       = 8'h80;
    localparam logic [7:0]  CMD_PROT_OFF  = 8'h20;
    localparam logic [7:0]  CMD_CHIP_CLR  = 8'h10;
    localparam logic [7:0]  CMD_ACLR_OFF  = 8'h40;
    localparam logic [7:0]  CMD_ACLR_ON   = 8'h50;
    localparam int          SECTOR_BYTES  = 128;
    localparam int          CLK_NS        = 10;
    // Write strobe phases, generous against the 100 ns pulse and setups
    localparam int          SETUP_NS      = 30;
    localparam int          PULSE_NS      = 120;
    localparam int          HOLD_NS       = 110;
    localparam int          SETUP_CYC     = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int          PULSE_CYC     = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int          HOLD_CYC      = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0]  CNT_RST       = 8'h00;
    typedef enum logic [2:0] {
        FUCD_OP_PROT_ON, FUCD_OP_PROT_OFF, FUCD_OP_CHIP_CLR,
        FUCD_OP_ACLR_OFF, FUCD_OP_ACLR_ON, FUCD_OP_PLAIN
    } fucd_op_e;
endpackage

/* File: verification/fucd_flash_model.sv */
// Behavioural flash device watching the host's write strobes
`timescale 1ns/1ns
module fucd_flash_model
    import fucd_pkg::*;
(
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0]        dq,
    input wire logic              dq_oe,
    input wire logic              ce_n,
    input wire logic              we_n,
    input wire logic              oe_n
);
    logic [ADDR_W-1:0] a_log [0:255];
    logic [7:0]        d_log [0:255];
    logic [ADDR_W-1:0] a_lat;
    int                n        = 0;
    logic              prot     = 1'b0;
    logic              aclr_off = 1'b0;
    logic              seq_ok   = 1'b1;
    logic              pend_on  = 1'b0;
    logic              pend_off = 1'b0;
    logic              cleared  = 1'b0;
    time               t_prev   = 0;
    time               gap_max  = 0;
    logic [7:0]        d_in;
    logic [14:0]       a_exp;
    // Write window: both strobes low with output gate high
    wire               wr_n     = ce_n | we_n | !oe_n;
    always @(negedge wr_n) a_lat = addr;
    // Undriven bus seen inverted so stale data never matches
    always @(posedge wr_n) begin
        d_in = dq_oe ? dq : ~dq;
        a_log[n] = a_lat;
        d_log[n] = d_in;
        if (n > 0 && $time - t_prev > gap_max) gap_max = $time - t_prev;
        t_prev = $time;
        a_exp = (n == 1 || n == 4) ? CMD_ADDR_B : CMD_ADDR_A;
        if (n == 0) begin
            seq_ok   = 1'b1;
            pend_on  = 1'b0;
            pend_off = 1'b0;
        end
        // Any off-sequence step clears seq_ok until the next operation restarts at n == 0
        if (n < 3 || (n < 6 && d_log[2] == CMD_EXT)) begin
            if (a_lat[14:0] != a_exp) seq_ok = 1'b0;
            if ((n % 3 == 0) && d_in != CMD_D1) seq_ok = 1'b0;
            if ((n % 3 == 1) && d_in != CMD_D2) seq_ok = 1'b0;
        end
        // Protect requests only take hold once sector data follows; clear and autoclear act at once
        if (n == 3 && pend_on) prot = 1'b1;
        if (n == 6 && pend_off) prot = 1'b0;
        if (n == 2 && seq_ok && d_in == CMD_PROT_ON) pend_on = 1'b1;
        if (n == 5 && seq_ok && d_log[2] == CMD_EXT) begin
            if (d_in == CMD_PROT_OFF) pend_off = 1'b1;
            if (d_in == CMD_CHIP_CLR) cleared = 1'b1;
            if (d_in == CMD_ACLR_OFF) aclr_off = 1'b1;
            if (d_in == CMD_ACLR_ON) aclr_off = 1'b0;
        end
        n = n + 1;
    end
endmodule

/* File: verification/fucd_host_tb.sv */
// Self-checking bench for the flash command sequence host
`timescale 1ns/1ns
module fucd_host_tb;
    import fucd_pkg::*;
    logic              clk = 1'b0, nrst = 1'b0, start = 1'b0, prefix = 1'b0;
    logic [2:0]        op = 3'h0;
    logic [9:0]        sector = 10'h000;
    logic [7:0]        wr_data = 8'h00, dq;
    logic              data_req, busy, done, dq_oe, ce_n, we_n, oe_n;
    logic [6:0]        data_idx;
    logic [ADDR_W-1:0] addr;
    int                err_count = 0, tests_run = 0, cyc = 0;
    logic              exp_prot = 1'b0, exp_aclr = 1'b0;
    always #5 clk = ~clk;
    fucd_host u_dut (.clk(clk), .nrst(nrst), .start(start), .op(op), .prefix(prefix),
        .sector(sector), .wr_data(wr_data), .data_req(data_req), .data_idx(data_idx),
        .busy(busy), .done(done), .flash_addr(addr), .flash_dq_out(dq), .flash_dq_oe(dq_oe),
        .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n));
    fucd_flash_model u_mdl (.addr(addr), .dq(dq), .dq_oe(dq_oe), .ce_n(ce_n), .we_n(we_n),
        .oe_n(oe_n));
    task automatic summarize();
        $display("errors %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    // Ceiling well above seven full operations
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            summarize();
        end
        if (data_req === 1'b1) wr_data <= #1 {1'b0, data_idx} ^ 8'h5a;
    end
    task automatic run_op(input logic [2:0] o, input logic p, input logic [9:0] s);
        int k, nc, ns;
        logic [7:0] last, ed;
        u_mdl.n = 0;
        u_mdl.gap_max = 0;
        u_mdl.cleared = 1'b0;
        @(posedge clk);
        #1 op = o; prefix = p; sector = s; start = 1'b1;
        @(posedge clk);
        #1 start = 1'b0;
        // Second request while busy must be ignored
        @(posedge clk);
        #1 op = 3'h2; start = 1'b1;
        repeat (3) @(posedge clk);
        #1 start = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 5000) begin
            @(negedge clk);
            k++;
        end
        check(k < 5000 && busy === 1'b1, "no done");
        @(negedge clk);
        check(done === 1'b0 && ce_n === 1'b1 && we_n === 1'b1 && busy === 1'b0,
              "done or pins stuck");
        if (o == 3'h0 || (o == 3'h5 && p)) exp_prot = 1'b1;
        if (o == 3'h1) exp_prot = 1'b0;
        if (o == 3'h3) exp_aclr = 1'b1;
        if (o == 3'h4) exp_aclr = 1'b0;
        check(u_mdl.prot === exp_prot, "protect state");
        check(u_mdl.aclr_off === exp_aclr, "autoclear state");
        check(u_mdl.cleared === (o == 3'h2), "chip clear");
        check(u_mdl.gap_max <= 300000, "byte gap");
        nc = (o == 3'h5) ? (p ? 3 : 0) : (o == 3'h0 ? 3 : 6);
        ns = (o == 3'h2) ? 0 : SECTOR_BYTES;
        case (o)
            3'h1: last = CMD_PROT_OFF;
            3'h2: last = CMD_CHIP_CLR;
            3'h3: last = CMD_ACLR_OFF;
            3'h4: last = CMD_ACLR_ON;
            default: last = CMD_PROT_ON;
        endcase
        check(u_mdl.n == nc + ns, "write count");
        for (int i = 0; i < nc; i++) begin
            ed = (i == nc - 1) ? last : (i % 3 == 0 ? CMD_D1 : (i % 3 == 1 ? CMD_D2 : CMD_EXT));
            check(u_mdl.a_log[i][14:0] === (i % 3 == 1 ? CMD_ADDR_B : CMD_ADDR_A),
                  "cmd addr");
            check(u_mdl.d_log[i] === ed, "cmd data");
        end
        for (int j = 0; j < ns; j++) begin
            check(u_mdl.a_log[nc+j] === {s, j[6:0]}, "sector addr");
            check(u_mdl.d_log[nc+j] === ({1'b0, j[6:0]} ^ 8'h5a), "sector data");
        end
    endtask
    initial begin
        repeat (2) @(posedge clk);
        check(ce_n === 1'b1 && we_n === 1'b1 && busy === 1'b0, "reset pins");
        #1 nrst = 1'b1;
        for (int t = 0; t < 5; t++) begin
            run_op(t[2:0], 1'b0, 10'h3ff - t[9:0]);
        end
        run_op(3'h5, 1'b1, 10'h000);
        run_op(3'h5, 1'b0, 10'h155);
        summarize();
    end
endmodule
